// ==== rtl/bsc_defs.vh ====
// Purpose: Shared constants of the boundary-scan chain tail and scan control block
// Assumes: 8-bit I/O register space with 6-bit addresses
// Notes:   Instruction codes are arbitrary local choices
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// I/O register addresses
`define BSC_CTRL_ADDR      6'h35
`define BSC_STAT_ADDR      6'h34

// Control register fields
`define BSC_DIS_BIT        7
`define BSC_PUD_BIT        4
`define BSC_VECTOR_TABLE_SELECT_BIT      1
`define BSC_VECTOR_CHANGE_ENABLE_BIT       0
`define BSC_CTRL_RESET     8'h00
`define BSC_CTRL_MASK      8'h93

// Status register fields
`define BSC_SRST_BIT       4
`define BSC_STAT_RESET     8'h00

// Timed double write window in system clock cycles
`define BSC_DIS_WINDOW     3'h4

// Chain geometry
`define BSC_CHAIN_LEN      97
`define BSC_PIN_COUNT      31
`define BSC_PIN_CELLS      93
`define BSC_CLK_EXT_POS    96
`define BSC_CLK_MAIN_POS   95
`define BSC_CLK_RC_POS     94
`define BSC_CLK_SLOW_POS   93

// Instruction register
`define BSC_IR_W           4
`define BSC_IR_EXTEST      4'h0
`define BSC_IR_SAMPLE      4'h2
`define BSC_IR_CORE_RESET  4'hC
`define BSC_IR_BYPASS      4'hF

`endif

// ==== rtl/bsc_pin_sync.v ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module bsc_pin_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // Raw and filtered levels
  input  wire [W-1:0] raw_in,
  output reg  [W-1:0] clean_out
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // Stage one is read only by stage two
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1    <= {W{1'b0}};
      stage2    <= {W{1'b0}};
      stage3    <= {W{1'b0}};
      clean_out <= {W{1'b0}};
    end else begin
      stage1    <= raw_in;
      stage2    <= stage1;
      stage3    <= stage2;
      clean_out <= (stage2 & stage3) | (clean_out & (stage2 | stage3)); // Hold on disagreement
    end
  end

endmodule // bsc_pin_sync

`default_nettype wire

// ==== rtl/bsc_scan_ctrl.v ====
// Purpose: Boundary-scan chain cells 96..0, test port controller and scan control registers
// Assumes: Test clock is sampled by sys_clk; CPU reaches registers over the I/O port
// Notes:   Test port is held in logic reset while disabled
//
// What this block does
// R01: Three cells per pin: data, control, pull-up
// R02: Cells 96..93 observe four clock sources
// R04: Port active with fuse and disable bit clear
// R05: Disable bit changes on double write within four
// R06: Software leaves disable bit alone during debug
// R07: Software sets disable bit when port unused
// R08: Control register 0x35, bits 7,4,1,0, reset zero
// R09: Status bit 4 set by scan-requested reset
// R10: Scan reset flag cleared by power-on or zero write
// R11: Cells capture, shift, update via test states
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"

module bsc_scan_ctrl (
  // Clock and power-on reset
  input  wire        sys_clk,
  input  wire        nrst,
  // CPU I/O register port
  input  wire [5:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        io_we,
  input  wire        io_re,
  output reg  [7:0]  io_rdata,
  // Test access port pins
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output wire        tdo_oe,
  input  wire        scan_port_fuse,
  // Observed clock sources
  input  wire        ext_clock_observe,
  input  wire        main_osc_observe,
  input  wire        rc_clock_observe,
  input  wire        slow_osc_observe,
  // Pin cells: pad level, core request and pad drive
  input  wire [30:0] pin_in,
  input  wire [30:0] core_out,
  input  wire [30:0] core_oe,
  input  wire [30:0] core_pue,
  output wire [30:0] pad_out,
  output wire [30:0] pad_oe,
  output wire [30:0] pad_pue,
  // Control outputs
  output wire        scan_port_active,
  output reg         core_reset_req,
  output wire        global_pullup_disable,
  output wire        vector_table_select,
  output wire        vector_change_enable
);

  // Test controller states
  localparam TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3, SDR = 4'h4, E1D = 4'h5,
             PDR = 4'h6, E2D = 4'h7, UDR = 4'h8, SIS = 4'h9, CIR = 4'hA, SIR = 4'hB,
             E1I = 4'hC, PIR = 4'hD, E2I = 4'hE, UIR = 4'hF;

  reg        rst_meta;
  reg        rst_n;
  wire [7:0] sync_q;
  reg        tck_q;
  reg  [3:0] tap_state;
  reg  [`BSC_IR_W-1:0] ir_shift;
  reg  [`BSC_IR_W-1:0] ir_active;
  reg  [`BSC_CHAIN_LEN-1:0] bs_shift;
  reg  [`BSC_PIN_CELLS-1:0] bs_update;
  reg        bypass_bit;
  reg        rst_shift;
  reg  [7:0] mcu_control;
  reg        scan_reset_flag;
  reg  [2:0] dis_window;
  reg        dis_pending_val;
  reg        next_tdo;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       fuse_s;
  wire       tck_rise;
  wire       tck_fall;
  wire       scan_port_disable;
  wire       extest_on;
  wire       ctrl_wr;
  wire       stat_wr;
  wire [`BSC_CHAIN_LEN-1:0] capture_vec;

  // Next test controller state from current state and mode select
  function [3:0] tap_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        TLR:     tap_next = m ? TLR : RTI;
        RTI:     tap_next = m ? SDS : RTI;
        SDS:     tap_next = m ? SIS : CDR;
        CDR:     tap_next = m ? E1D : SDR;
        SDR:     tap_next = m ? E1D : SDR;
        E1D:     tap_next = m ? UDR : PDR;
        PDR:     tap_next = m ? E2D : PDR;
        E2D:     tap_next = m ? UDR : SDR;
        UDR:     tap_next = m ? SDS : RTI;
        SIS:     tap_next = m ? TLR : CIR;
        CIR:     tap_next = m ? E1I : SIR;
        SIR:     tap_next = m ? E1I : SIR;
        E1I:     tap_next = m ? UIR : PIR;
        PIR:     tap_next = m ? E2I : PIR;
        E2I:     tap_next = m ? UIR : SIR;
        UIR:     tap_next = m ? SDS : RTI;
        default: tap_next = TLR;
      endcase
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Test port pins, fuse and clock observers pass the three-stage filter; pin_in is captured directly
  bsc_pin_sync #(
    .W (8)
  ) u_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .raw_in    ({slow_osc_observe, rc_clock_observe, main_osc_observe, ext_clock_observe,
                 scan_port_fuse, tdi, tms, tck}),
    .clean_out (sync_q)
  );

  assign tck_s  = sync_q[0];
  assign tms_s  = sync_q[1];
  assign tdi_s  = sync_q[2];
  assign fuse_s = sync_q[3];

  // Test clock edge detection
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      tck_q <= 1'b0;
    else
      tck_q <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // Port enabled only with fuse programmed and disable bit clear
  assign scan_port_disable = mcu_control[`BSC_DIS_BIT];
  assign scan_port_active  = fuse_s & ~scan_port_disable; // [R04]
  assign extest_on         = scan_port_active & (ir_active == `BSC_IR_EXTEST);

  // Capture values: clock observers on top, three cells per pin below
  assign capture_vec[`BSC_CLK_EXT_POS]  = sync_q[4]; // [R02]
  assign capture_vec[`BSC_CLK_MAIN_POS] = sync_q[5]; // [R02]
  assign capture_vec[`BSC_CLK_RC_POS]   = sync_q[6]; // [R02]
  assign capture_vec[`BSC_CLK_SLOW_POS] = sync_q[7]; // [R02]

  // Pin k uses cells 3k+2 data, 3k+1 control, 3k pull-up; pad mux per pin
  genvar k;
  generate
    for (k = 0; k < `BSC_PIN_COUNT; k = k + 1) begin : g_pin
      assign capture_vec[3*k+2] = pin_in[k];   // [R01]
      assign capture_vec[3*k+1] = core_oe[k];  // [R01]
      assign capture_vec[3*k]   = core_pue[k]; // [R01]
      assign pad_out[k] = extest_on ? bs_update[3*k+2] : core_out[k];
      assign pad_oe[k]  = extest_on ? bs_update[3*k+1] : core_oe[k];
      assign pad_pue[k] = extest_on ? bs_update[3*k]   : core_pue[k];
    end
  endgenerate

  // Test controller, instruction and data registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state      <= TLR;
      ir_shift       <= `BSC_IR_BYPASS;
      ir_active      <= `BSC_IR_BYPASS;
      bs_shift       <= {`BSC_CHAIN_LEN{1'b0}};
      bs_update      <= {`BSC_PIN_CELLS{1'b0}};
      bypass_bit     <= 1'b0;
      rst_shift      <= 1'b0;
      core_reset_req <= 1'b0;
    end else if (!scan_port_active) begin
      tap_state      <= TLR; // [R04]
      ir_active      <= `BSC_IR_BYPASS;
      core_reset_req <= 1'b0;
    end else if (tck_rise) begin
      tap_state <= tap_next(tap_state, tms_s); // [R11]
      if (tap_state == TLR) begin
        ir_active      <= `BSC_IR_BYPASS;
        core_reset_req <= 1'b0;
      end
      case (tap_state)
        CIR: ir_shift <= {{(`BSC_IR_W-1){1'b0}}, 1'b1};
        SIR: ir_shift <= {tdi_s, ir_shift[`BSC_IR_W-1:1]};
        UIR: ir_active <= ir_shift;
        CDR: begin
          bypass_bit <= 1'b0;
          rst_shift  <= core_reset_req;
          if (ir_active == `BSC_IR_EXTEST || ir_active == `BSC_IR_SAMPLE)
            bs_shift <= capture_vec; // [R11]
        end
        SDR: begin
          bypass_bit <= tdi_s;
          rst_shift  <= tdi_s;
          if (ir_active == `BSC_IR_EXTEST || ir_active == `BSC_IR_SAMPLE)
            bs_shift <= {tdi_s, bs_shift[`BSC_CHAIN_LEN-1:1]}; // [R11]
        end
        UDR: begin
          if (ir_active == `BSC_IR_EXTEST || ir_active == `BSC_IR_SAMPLE)
            bs_update <= bs_shift[`BSC_PIN_CELLS-1:0]; // [R11]
          if (ir_active == `BSC_IR_CORE_RESET)
            core_reset_req <= rst_shift; // [R09]
        end
        default: ;
      endcase
    end
  end

  // Output bit of the selected register, changed on test clock falling edge
  always @* begin
    next_tdo = bypass_bit;
    if (tap_state == SIR)
      next_tdo = ir_shift[0];
    else if (ir_active == `BSC_IR_EXTEST || ir_active == `BSC_IR_SAMPLE)
      next_tdo = bs_shift[0];
    else if (ir_active == `BSC_IR_CORE_RESET)
      next_tdo = rst_shift;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      tdo <= 1'b0;
    else if (tck_fall)
      tdo <= next_tdo; // [R11]
  end

  assign tdo_oe = scan_port_active & (tap_state == SDR || tap_state == SIR);

  // Register write decode
  assign ctrl_wr = io_we & (io_addr == `BSC_CTRL_ADDR);
  assign stat_wr = io_we & (io_addr == `BSC_STAT_ADDR);

  // Control register with timed double write on the disable bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcu_control     <= `BSC_CTRL_RESET; // [R08]
      dis_window      <= 3'h0;
      dis_pending_val <= 1'b0;
    end else begin
      if (dis_window != 3'h0)
        dis_window <= dis_window - 3'h1;
      if (ctrl_wr) begin
        mcu_control[`BSC_PUD_BIT]   <= io_wdata[`BSC_PUD_BIT];   // [R08]
        mcu_control[`BSC_VECTOR_TABLE_SELECT_BIT] <= io_wdata[`BSC_VECTOR_TABLE_SELECT_BIT]; // [R08]
        mcu_control[`BSC_VECTOR_CHANGE_ENABLE_BIT]  <= io_wdata[`BSC_VECTOR_CHANGE_ENABLE_BIT];  // [R08]
        if (dis_window != 3'h0 && dis_pending_val == io_wdata[`BSC_DIS_BIT]) begin
          mcu_control[`BSC_DIS_BIT] <= io_wdata[`BSC_DIS_BIT]; // [R05]
          dis_window <= 3'h0;
        end else begin
          dis_pending_val <= io_wdata[`BSC_DIS_BIT]; // [R05]
          dis_window      <= `BSC_DIS_WINDOW;
        end
      end
    end
  end

  // Scan reset flag: set wins over software clear, power-on clears
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      scan_reset_flag <= 1'b0; // [R10]
    else if (core_reset_req)
      scan_reset_flag <= 1'b1; // [R09]
    else if (stat_wr && !io_wdata[`BSC_SRST_BIT])
      scan_reset_flag <= 1'b0; // [R10]
  end

  // Read data, one cycle after the read strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      io_rdata <= 8'h00;
    else if (io_re) begin
      if (io_addr == `BSC_CTRL_ADDR)
        io_rdata <= mcu_control & `BSC_CTRL_MASK; // [R08]
      else if (io_addr == `BSC_STAT_ADDR)
        io_rdata <= `BSC_STAT_RESET | ({7'h00, scan_reset_flag} << `BSC_SRST_BIT);
      else
        io_rdata <= 8'h00;
    end
  end

  assign global_pullup_disable = mcu_control[`BSC_PUD_BIT];
  assign vector_table_select   = mcu_control[`BSC_VECTOR_TABLE_SELECT_BIT];
  assign vector_change_enable  = mcu_control[`BSC_VECTOR_CHANGE_ENABLE_BIT];

endmodule // bsc_scan_ctrl

`default_nettype wire

// ==== sim/bsc_scan_ctrl_asserts.sv ====
// Purpose: Port assertions of the scan control block
// Assumes: One sys_clk domain
// Notes:   Bound below the module
`timescale 1ns/1ps
`default_nettype none
module bsc_scan_ctrl_asserts (
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [7:0] io_rdata,
  input wire logic       scan_port_fuse,
  input wire logic       tdo_oe,
  input wire logic       scan_port_active,
  input wire logic       core_reset_req,
  input wire logic       global_pullup_disable,
  input wire logic       vector_table_select,
  input wire logic       vector_change_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Port gating
  AST_NO_FUSE: assert property ((!scan_port_fuse) [*8] |-> !scan_port_active) else $error("no fuse");
  AST_OE_GATE: assert property ($rose(tdo_oe) |-> scan_port_active && $past(scan_port_active, 8)) else $error("tdo driven idle");
  AST_IDLE_RST: assert property ((!scan_port_active) [*3] |-> !core_reset_req) else $error("idle req");
  // Disable bit moves only on a second matching write
  AST_DIS_TWICE: assert property (scan_port_fuse [*8] ##1 $changed(scan_port_active) |-> $past(io_we)
    && $past(io_addr) == 6'h35 && $past(io_wdata[7]) != scan_port_active
    && ($past(io_we, 2) || $past(io_we, 3) || $past(io_we, 4) || $past(io_we, 5))) else $error("lone write");
  // Register port
  AST_CTRL_WR: assert property (io_we && io_addr == 6'h35 |=> {global_pullup_disable, vector_table_select,
    vector_change_enable} == {$past(io_wdata[4]), $past(io_wdata[1:0])}) else $error("ctrl write");
  AST_CTRL_RD: assert property (io_re && !io_we && io_addr == 6'h35 |=> io_rdata[6:0] == {2'h0,
    $past(global_pullup_disable), 2'h0, $past(vector_table_select), $past(vector_change_enable)})
    else $error("ctrl read");
  AST_UNMAPPED: assert property (io_re && io_addr != 6'h35 && io_addr != 6'h34 |=> io_rdata == 8'h00)
    else $error("unmapped read");
  AST_STAT_RD: assert property (io_re && io_addr == 6'h34 |=> io_rdata[7:5] == 3'h0 && io_rdata[3:0] == 4'h0
    && (io_rdata[4] || !$past(core_reset_req, 2))) else $error("status read");
endmodule // bsc_scan_ctrl_asserts
bind bsc_scan_ctrl bsc_scan_ctrl_asserts u_chk (.sys_clk, .nrst, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata,
  .scan_port_fuse, .tdo_oe, .scan_port_active, .core_reset_req, .global_pullup_disable, .vector_table_select,
  .vector_change_enable);
`default_nettype wire

// ==== sim/bsc_tap_model.sv ====
// Purpose: Test controller on the scan port
// Assumes: 800 ns test clock, low between frames
// Notes:   Calls start on a sys_clk falling edge
`timescale 1ns/1ps
`default_nettype none
module bsc_tap_model (
  // Test port pins
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock, tdo read late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #400 tck = 1'b1;
    #390 q = tdo;
    #10 tck = 1'b0;
  endtask
  // Five ones reach logic reset, then idle
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
  endtask
  // Idle, capture, n shifts LSB first, update, idle
  task automatic scan(input bit ir, input int n, input logic [96:0] din, output logic [96:0] dout);
    logic q;
    dout = '0;
    step(1'b1, tdi, q);
    if (ir)
      step(1'b1, tdi, q);
    step(1'b0, tdi, q);
    step(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule // bsc_tap_model
`default_nettype wire

// ==== sim/bsc_scan_ctrl_bench.sv ====
// Purpose: Self-checking bench of the scan control block
// Assumes: Controller model on the test port
// Notes:   Chain images are built from pin inputs or from pad outputs
`timescale 1ns/1ps
`default_nettype none
module bsc_scan_ctrl_bench;
  logic        sys_clk, nrst, io_we, io_re, tck, tms, tdi, tdo, tdo_oe, scan_port_fuse, scan_port_active;
  logic        core_reset_req, global_pullup_disable, vector_table_select, vector_change_enable;
  logic [5:0]  io_addr = 6'h00;
  logic [7:0]  io_wdata = 8'h00, io_rdata;
  logic [3:0]  clks = 4'hB;
  logic [30:0] pin_in = 31'h2A5A1234, core_out = 31'h0F0F1234, core_oe = 31'h3C3C5678, core_pue = 31'h01234567;
  logic [30:0] pad_out, pad_oe, pad_pue;
  logic [96:0] got, pat = 97'h1_2345_6789_ABCD_EF01_2345_6789;
  int          n_mismatch = 0, checked = 0, cycles = 0;
  // Block and far-side controller
  bsc_scan_ctrl uut (.sys_clk, .nrst, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .tck, .tms, .tdi, .tdo,
    .tdo_oe, .scan_port_fuse, .ext_clock_observe(clks[3]), .main_osc_observe(clks[2]),
    .rc_clock_observe(clks[1]), .slow_osc_observe(clks[0]), .pin_in, .core_out, .core_oe, .core_pue, .pad_out,
    .pad_oe, .pad_pue, .scan_port_active, .core_reset_req, .global_pullup_disable, .vector_table_select,
    .vector_change_enable);
  bsc_tap_model tap (.tck, .tms, .tdi, .tdo);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [96:0] g, input logic [96:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Chain image: clocks on top, data/control/pull-up per pin
  function automatic logic [96:0] chain(input logic [3:0] c, input logic [30:0] d, o, u);
    chain = {c, 93'h0};
    for (int k = 0; k < 31; k++)
      chain[3*k +: 3] = {d[k], o[k], u[k]};
  endfunction
  // Register port cycles
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_we <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge sys_clk);
    io_we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    io_re <= 1'b1;
    io_addr <= a;
    @(posedge sys_clk);
    io_re <= 1'b0;
    @(negedge sys_clk);
    chk({89'h0, io_rdata}, {89'h0, e});
  endtask
  // Test port frames
  task automatic sc(input bit ir, input int n, input logic [96:0] din);
    @(negedge sys_clk);
    tap.scan(ir, n, din, got);
    // The update edge lands one filter delay after the last test clock rise
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic ld(input logic [3:0] c);
    sc(1'b1, 4, {93'h0, c});
    chk({93'h0, got[3:0]}, 97'h1);
  endtask
  task automatic t_regs();
    rd(6'h35, 8'h00);
    rd(6'h34, 8'h00);
    wr(6'h35, 8'hFF);
    rd(6'h35, 8'h13);
    chk({94'h0, global_pullup_disable, vector_table_select, vector_change_enable}, 97'h7);
    wr(6'h00, 8'hFF);
    rd(6'h00, 8'h00);
    wr(6'h35, 8'h00);
    $display("regs end");
  endtask
  task automatic t_chain();
    @(negedge sys_clk);
    tap.reset_tap();
    ld(4'h2);
    sc(1'b0, 97, 97'h0);
    chk(got, chain(clks, pin_in, core_oe, core_pue));
    ld(4'h0);
    sc(1'b0, 97, pat);
    repeat (10) @(posedge sys_clk);
    chk(chain(pat[96:93], pad_out, pad_oe, pad_pue), pat);
    @(negedge sys_clk);
    tap.reset_tap();
    chk({4'h0, pad_out, pad_oe, pad_pue}, {4'h0, core_out, core_oe, core_pue});
    $display("chain end");
  endtask
  task automatic t_reset();
    ld(4'hC);
    sc(1'b0, 1, 97'h1);
    chk({96'h0, core_reset_req}, 97'h1);
    rd(6'h34, 8'h10);
    sc(1'b0, 1, 97'h0);
    rd(6'h34, 8'h10);
    wr(6'h34, 8'h00);
    rd(6'h34, 8'h00);
    ld(4'hC);
    sc(1'b0, 1, 97'h1);
    wr(6'h35, 8'h13);
    rd(6'h34, 8'h10);
    // Mid-run power-on reset clears the flag, the request and the control bits
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk({96'h0, core_reset_req}, 97'h0);
    rd(6'h34, 8'h00);
    rd(6'h35, 8'h00);
    $display("reset end");
  endtask
  task automatic t_dis();
    wr(6'h35, 8'h80); // no debug session is running
    wr(6'h35, 8'h80); // port treated as unconnected
    rd(6'h35, 8'h80);
    chk({95'h0, scan_port_active, tdo_oe}, 97'h0);
    wr(6'h35, 8'h00);
    repeat (4) @(posedge sys_clk);
    wr(6'h35, 8'h00);
    rd(6'h35, 8'h80);
    wr(6'h35, 8'h00);
    rd(6'h35, 8'h00);
    chk({96'h0, scan_port_active}, 97'h1);
    scan_port_fuse <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({96'h0, scan_port_active}, 97'h0);
    $display("disable end");
  endtask
  initial begin
    nrst = 1'b0;
    io_we = 1'b0;
    io_re = 1'b0;
    scan_port_fuse = 1'b1;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    t_regs();
    t_chain();
    t_reset();
    t_dis();
    final_report();
  end
endmodule // bsc_scan_ctrl_bench
`default_nettype wire
